// File: logic/sdis_host.sv
// Controller end: power-up init, refresh timing, self-refresh entry/exit
`timescale 1ns/10ps
module sdis_host import sdis_pkg::*; #(
	parameter int unsigned STABLE_CYCLES = STABLE_CYC,
	parameter int unsigned BURST_COUNT = BURST_REFRESHES,
	parameter bit REFRESH_FIRST = 1'b0,
	parameter bit BURST_MODE = 1'b1
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic self_req_i,
	input wire logic wake_req_i,
	input wire logic [MODE_W-1:0] mode_i,
	output logic ready_o,
	output logic in_self_o,
	sdis_link_if.ctrl link
);
	sdis_host_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [CNT_W-1:0] refs_q, refs_d;
	logic [CNT_W-1:0] trefi_q;
	logic cke_q, cke_d;
	logic dqm_q, dqm_d;
	logic mrs_done_q, mrs_done_d;
	logic [3:0] cmd_q, cmd_d;
	logic [MODE_W-1:0] addr_q, addr_d;
	logic [1:0] bank_q, bank_d;
	logic ref_due_q;
	wire cnt_zero = (cnt_q == '0);
	wire refs_done = (refs_q == '0);
	wire [CNT_W-1:0] stable_len = CNT_W'(STABLE_CYCLES - 1);
	wire [CNT_W-1:0] tras_len = CNT_W'(TRAS_CYC);
	wire [CNT_W-1:0] txsr_len = CNT_W'(TXSR_CYC);
	wire [CNT_W-1:0] burst_len = CNT_W'(BURST_COUNT);
	wire [CNT_W-1:0] init_refs = CNT_W'(INIT_REFRESHES);
	// Due flag and timer reload each add a cycle to the period
	wire [CNT_W-1:0] trefi_len = CNT_W'(TREFI_CYC - 2);
	wire [CNT_W-1:0] init_wait = CNT_W'(TXSR_CYC);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q == '0 ? '0 : cnt_q - CNT_W'(1);
		refs_d = refs_q;
		cke_d = cke_q;
		dqm_d = dqm_q;
		mrs_done_d = mrs_done_q;
		cmd_d = CMD_NOP;
		addr_d = '0;
		bank_d = '0;
		unique case (state_q)
			SDIS_HC_POWER: begin
				cke_d = 1'b0;
				dqm_d = 1'b1;
				if (cnt_zero) begin
					cke_d = 1'b1;
					cnt_d = init_wait;
					state_d = SDIS_HC_PRE;
				end
			end
			SDIS_HC_PRE: begin
				if (cnt_zero) begin
					cmd_d = CMD_PRECHARGE;
					addr_d = MODE_W'(1) << AP_BIT;
					bank_d = BANK_ALL;
					cnt_d = init_wait;
					refs_d = init_refs;
					state_d = REFRESH_FIRST ? SDIS_HC_REF : SDIS_HC_MRS;
				end
			end
			SDIS_HC_REF: begin
				if (cnt_zero) begin
					if (!refs_done) begin
						cmd_d = CMD_REFRESH;
						refs_d = refs_q - CNT_W'(1);
						cnt_d = init_wait;
					end else if (mrs_done_q) begin
						dqm_d = 1'b0;
						state_d = SDIS_HC_READY;
					end else begin
						state_d = SDIS_HC_MRS;
					end
				end
			end
			SDIS_HC_MRS: begin
				if (cnt_zero) begin
					cmd_d = CMD_MODE_SET;
					addr_d = mode_i;
					mrs_done_d = 1'b1;
					cnt_d = init_wait;
					state_d = SDIS_HC_REF;
				end
			end
			SDIS_HC_READY: begin
				if (self_req_i) begin
					refs_d = BURST_MODE ? burst_len : '0;
					state_d = SDIS_HC_BURST_IN;
				end else if (ref_due_q && cnt_zero) begin
					cmd_d = CMD_REFRESH;
					cnt_d = init_wait;
				end
			end
			SDIS_HC_BURST_IN: begin
				if (cnt_zero) begin
					if (!refs_done) begin
						cmd_d = CMD_REFRESH;
						refs_d = refs_q - CNT_W'(1);
						cnt_d = init_wait;
					end else begin
						state_d = SDIS_HC_SELF_ENTER;
					end
				end
			end
			SDIS_HC_SELF_ENTER: begin
				cmd_d = CMD_REFRESH;
				cke_d = 1'b0;
				cnt_d = tras_len;
				state_d = SDIS_HC_SELF_HOLD;
			end
			SDIS_HC_SELF_HOLD: begin
				cke_d = 1'b0;
				if (cnt_zero && wake_req_i) begin
					cmd_d = CMD_DESEL;
					cke_d = 1'b1;
					cnt_d = txsr_len;
					state_d = SDIS_HC_SELF_EXIT;
				end
			end
			SDIS_HC_SELF_EXIT: begin
				cmd_d = CMD_DESEL;
				if (cnt_zero) begin
					refs_d = BURST_MODE ? burst_len : '0;
					state_d = SDIS_HC_BURST_OUT;
				end
			end
			SDIS_HC_BURST_OUT: begin
				if (cnt_zero) begin
					if (!refs_done) begin
						cmd_d = CMD_REFRESH;
						refs_d = refs_q - CNT_W'(1);
						cnt_d = init_wait;
					end else begin
						state_d = SDIS_HC_READY;
					end
				end
			end
			default: state_d = SDIS_HC_POWER;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= SDIS_HC_POWER;
			cnt_q <= stable_len;
			refs_q <= '0;
			cke_q <= 1'b0;
			dqm_q <= 1'b1;
			mrs_done_q <= 1'b0;
			cmd_q <= CMD_NOP;
			addr_q <= '0;
			bank_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			refs_q <= refs_d;
			cke_q <= cke_d;
			dqm_q <= dqm_d;
			mrs_done_q <= mrs_done_d;
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			bank_q <= bank_d;
		end
	end

	// Refresh interval timer for normal operation
	always_ff @(posedge clock_i) begin
		if (rst_i || state_q != SDIS_HC_READY) begin
			trefi_q <= trefi_len;
			ref_due_q <= 1'b0;
		end else if (cmd_d == CMD_REFRESH) begin
			trefi_q <= trefi_len;
			ref_due_q <= 1'b0;
		end else if (trefi_q == '0) begin
			ref_due_q <= 1'b1;
		end else begin
			trefi_q <= trefi_q - CNT_W'(1);
		end
	end

	assign link.clk_en = cke_q;
	assign link.cs_n = cmd_q[3];
	assign link.ras_n = cmd_q[2];
	assign link.cas_n = cmd_q[1];
	assign link.we_n = cmd_q[0];
	assign link.dqm = dqm_q;
	assign link.bank = bank_q;
	assign link.addr = addr_q;
	assign ready_o = (state_q == SDIS_HC_READY);
	assign in_self_o = (state_q == SDIS_HC_SELF_HOLD);
endmodule : sdis_host

// File: logic/sdis_pkg.sv
// Constants and types shared by both ends of the init/self-refresh link
package sdis_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned STABLE_US = 200;
	localparam int unsigned STABLE_CYC = (STABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TRAS_NS = 42;
	localparam int unsigned TRAS_CYC = (TRAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TRC_NS = 63;
	localparam int unsigned TIS_NS = 2;
	localparam int unsigned TXSR_CYC = (TRC_NS + TIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TREFI_NS = 7800;
	localparam int unsigned TREFI_CYC = TREFI_NS / CLK_PERIOD_NS;
	localparam int unsigned INIT_REFRESHES = 2;
	localparam int unsigned BURST_REFRESHES = 8192;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned MODE_W = 13;
	localparam logic [MODE_W-1:0] MODE_DEFAULT = 13'h0030;
	localparam logic [1:0] BANK_ALL = 2'h3;
	// Command encoding {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DESEL = 4'h8;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_MODE_SET = 4'h0;
	localparam int unsigned AP_BIT = 10;
	typedef enum logic [2:0] {
		SDIS_DEV_OFF, SDIS_DEV_IDLE, SDIS_DEV_SELF
	} sdis_dev_state_t;
	typedef enum logic [3:0] {
		SDIS_HC_POWER, SDIS_HC_PRE, SDIS_HC_REF, SDIS_HC_MRS, SDIS_HC_READY,
		SDIS_HC_BURST_IN, SDIS_HC_SELF_ENTER, SDIS_HC_SELF_HOLD,
		SDIS_HC_SELF_EXIT, SDIS_HC_BURST_OUT
	} sdis_host_state_t;
endpackage : sdis_pkg

// File: logic/sdis_link_if.sv
// Command pins between memory controller and SDRAM device
`timescale 1ns/10ps
interface sdis_link_if;
	logic clk_en;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic dqm;
	logic [1:0] bank;
	logic [12:0] addr;
	modport ctrl (output clk_en, output cs_n, output ras_n, output cas_n,
		output we_n, output dqm, output bank, output addr);
	modport mem (input clk_en, input cs_n, input ras_n, input cas_n,
		input we_n, input dqm, input bank, input addr);
endinterface : sdis_link_if

// File: logic/sdis_device.sv
// Device end: command decode for init and self-refresh tracking
`timescale 1ns/10ps
module sdis_device import sdis_pkg::*; (
	input wire logic clock_i,
	input wire logic rst_i,
	sdis_link_if.mem link,
	output logic initialized_o,
	output logic self_refresh_o,
	output logic [MODE_W-1:0] mode_o,
	output logic [CNT_W-1:0] refresh_count_o,
	output logic dq_hiz_o
);
	sdis_dev_state_t state_q, state_d;
	logic cke_prev_q;
	logic precharged_q;
	logic mrs_q;
	logic [CNT_W-1:0] refs_q;
	logic [MODE_W-1:0] mode_q;
	wire [3:0] cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
	wire active = link.clk_en && cke_prev_q;
	wire is_pre_all = active && cmd == CMD_PRECHARGE && link.addr[AP_BIT];
	wire is_mrs = active && cmd == CMD_MODE_SET;
	wire is_ref = active && cmd == CMD_REFRESH;
	wire is_self = cke_prev_q && !link.clk_en && cmd == CMD_REFRESH;
	wire refs_ok = (refs_q >= CNT_W'(INIT_REFRESHES));
	wire [CNT_W-1:0] refs_inc = (refs_q == '1) ? refs_q : refs_q + CNT_W'(1);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			SDIS_DEV_OFF: if (precharged_q && mrs_q && refs_ok) begin
				state_d = SDIS_DEV_IDLE;
			end
			SDIS_DEV_IDLE: if (is_self) begin
				state_d = SDIS_DEV_SELF;
			end
			SDIS_DEV_SELF: if (link.clk_en) begin
				state_d = SDIS_DEV_IDLE;
			end
			default: state_d = SDIS_DEV_OFF;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= SDIS_DEV_OFF;
			cke_prev_q <= 1'b0;
			precharged_q <= 1'b0;
			mrs_q <= 1'b0;
			refs_q <= '0;
			mode_q <= MODE_DEFAULT;
		end else begin
			state_q <= state_d;
			cke_prev_q <= link.clk_en;
			if (state_q != SDIS_DEV_SELF) begin
				if (is_pre_all) begin
					precharged_q <= 1'b1;
				end
				if (is_mrs && precharged_q) begin
					mrs_q <= 1'b1;
					mode_q <= link.addr;
				end
				if (is_ref) begin
					refs_q <= refs_inc;
				end
			end
		end
	end

	assign initialized_o = (state_q != SDIS_DEV_OFF);
	assign self_refresh_o = (state_q == SDIS_DEV_SELF);
	assign mode_o = mode_q;
	assign refresh_count_o = refs_q;
	assign dq_hiz_o = link.dqm || !initialized_o;
endmodule : sdis_device

// File: tb/sdis_link_checker.sv
// Assertions on the command pins between the two ends
`timescale 1ns/10ps
module sdis_link_checker import sdis_pkg::*; (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic clk_en,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic dqm,
	input wire logic [1:0] bank,
	input wire logic [12:0] addr
);
	wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
	wire logic is_pre = clk_en && cmd == CMD_PRECHARGE;
	wire logic is_mrs = clk_en && cmd == CMD_MODE_SET;
	wire logic is_ref = clk_en && cmd == CMD_REFRESH;
	wire logic idle = cs_n || cmd == CMD_NOP;
	logic pre_q;
	logic mrs_q;
	logic [1:0] ref_q;
	logic [7:0] gap_q;
	always_ff @(posedge clock_i) begin
		pre_q <= !rst_i && (pre_q || is_pre);
		mrs_q <= !rst_i && (mrs_q || is_mrs);
		ref_q <= rst_i ? 2'h0 : (is_ref && ref_q != 2'h2) ? ref_q + 2'h1 : ref_q;
		gap_q <= (rst_i || !clk_en || is_ref || !mrs_q) ? 8'h00 : gap_q + 8'h01;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence s_exit;
		cs_n ##1 idle;
	endsequence
	AST_PWR_IDLE: assert property (disable iff (1'b0)
		rst_i |=> !clk_en && dqm && cmd == CMD_NOP)
		else $error("controller not idle in reset");
	AST_STABLE: assert property ($fell(rst_i) |-> !clk_en [*8])
		else $error("clock enable raised too early");
	AST_MASK_RISE: assert property ($rose(clk_en) && !pre_q |-> dqm)
		else $error("mask low as clock enable rose");
	AST_PRE_ALL: assert property (is_pre && !mrs_q |->
		addr[AP_BIT] && bank == BANK_ALL)
		else $error("init precharge not all banks");
	AST_MRS_ORDER: assert property (is_mrs |-> pre_q)
		else $error("mode set before precharge");
	AST_ENTRY: assert property ($fell(clk_en) |->
		cmd == CMD_REFRESH && mrs_q && ref_q == 2'h2)
		else $error("bad self-refresh entry");
	AST_SELF_HOLD: assert property ($fell(clk_en) |=> !clk_en)
		else $error("self-refresh left too soon");
	AST_EXIT: assert property ($rose(clk_en) && pre_q |-> s_exit)
		else $error("command too soon after exit");
	AST_REF_GAP: assert property (gap_q <= 8'(2 * TREFI_CYC))
		else $error("refresh interval too long");
endmodule : sdis_link_checker

// File: tb/tb_top.sv
// Testbench joining controller and device ends over the command link
`timescale 1ns/10ps
module tb_top;
	import sdis_pkg::*;
	localparam logic [MODE_W-1:0] MODE_VAL = 13'h0022;
	localparam int BURST = 4;
	logic clock_i;
	logic rst_i;
	logic self_req;
	logic wake_req;
	logic ready;
	logic in_self;
	logic init_done;
	logic self_ref;
	logic hiz;
	logic [MODE_W-1:0] mode_q;
	logic [CNT_W-1:0] ref_cnt;
	int n_errors = 0;
	int comparisons = 0;
	sdis_link_if sdis_link_if_inst ();
	sdis_host #(.STABLE_CYCLES(10), .BURST_COUNT(BURST)) sdis_host_inst (
		.clock_i(clock_i), .rst_i(rst_i), .self_req_i(self_req),
		.wake_req_i(wake_req), .mode_i(MODE_VAL), .ready_o(ready),
		.in_self_o(in_self), .link(sdis_link_if_inst.ctrl));
	sdis_device sdis_device_inst (.clock_i(clock_i), .rst_i(rst_i),
		.link(sdis_link_if_inst.mem), .initialized_o(init_done),
		.self_refresh_o(self_ref), .mode_o(mode_q),
		.refresh_count_o(ref_cnt), .dq_hiz_o(hiz));
	sdis_link_checker sdis_link_checker_inst (.clock_i(clock_i),
		.rst_i(rst_i), .clk_en(sdis_link_if_inst.clk_en),
		.cs_n(sdis_link_if_inst.cs_n), .ras_n(sdis_link_if_inst.ras_n),
		.cas_n(sdis_link_if_inst.cas_n), .we_n(sdis_link_if_inst.we_n),
		.dqm(sdis_link_if_inst.dqm), .bank(sdis_link_if_inst.bank),
		.addr(sdis_link_if_inst.addr));
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic tick;
		@(posedge clock_i);
		#1;
	endtask : tick
	task automatic do_reset;
		@(posedge clock_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rst_i <= 1'b0;
	endtask : do_reset
	task automatic test_init;
		tick();
		chk(init_done, 16'h0);
		chk(hiz, 16'h1);
		for (int i = 0; i < 400 && ready !== 1'b1; i++)
			tick();
		chk(ready, 16'h1);
		chk(init_done, 16'h1);
		chk(mode_q, 16'(MODE_VAL));
		chk(16'(ref_cnt >= 2), 16'h1);
		chk(hiz, 16'h0);
		$display("test_init finished");
	endtask : test_init
	task automatic test_refresh;
		logic [CNT_W-1:0] c0;
		int gap;
		c0 = ref_cnt;
		for (int i = 0; i < 200 && ref_cnt === c0; i++)
			tick();
		c0 = ref_cnt;
		gap = 0;
		while (gap < 200 && ref_cnt === c0) begin
			tick();
			gap++;
		end
		chk(16'(gap <= TREFI_CYC), 16'h1);
		chk(ref_cnt, c0 + 16'h1);
		$display("test_refresh finished");
	endtask : test_refresh
	task automatic test_self;
		logic [CNT_W-1:0] c0;
		logic ok;
		c0 = ref_cnt;
		@(posedge clock_i);
		self_req <= 1'b1;
		for (int i = 0; i < 200 && in_self !== 1'b1; i++)
			tick();
		tick();
		chk(self_ref, 16'h1);
		chk(16'(ref_cnt >= c0 + BURST), 16'h1);
		c0 = ref_cnt;
		ok = 1'b1;
		repeat (20) begin
			tick();
			ok = ok & (self_ref === 1'b1);
		end
		chk(ok, 16'h1);
		chk(ref_cnt, c0);
		@(posedge clock_i);
		self_req <= 1'b0;
		wake_req <= 1'b1;
		for (int i = 0; i < 200 && ready !== 1'b1; i++)
			tick();
		@(posedge clock_i);
		wake_req <= 1'b0;
		tick();
		chk(self_ref, 16'h0);
		chk(in_self, 16'h0);
		chk(16'(ref_cnt >= c0 + BURST), 16'h1);
		chk(init_done, 16'h1);
		$display("test_self finished");
	endtask : test_self
	initial begin
		rst_i = 1'b1;
		self_req = 1'b0;
		wake_req = 1'b0;
		do_reset();
		test_init();
		test_refresh();
		test_self();
		do_reset();
		test_init();
		conclude();
	end
	initial begin
		repeat (5000) @(posedge clock_i);
		n_errors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		conclude();
	end
endmodule : tb_top
